//--- gp_defines.vh
`ifndef GP_DEFINES_VH
`define GP_DEFINES_VH

// APB address fields: port group in bits 7:5, register in bits 4:2
`define GP_ADDR_W 8
`define GP_GRP_HI 7
`define GP_GRP_LO 5
`define GP_REG_HI 4
`define GP_REG_LO 2

// Port groups (byte offset = group * 0x20)
`define GP_GRP_P2 3'h0
`define GP_GRP_P3 3'h1
`define GP_GRP_P6 3'h2
`define GP_GRP_P7 3'h3
`define GP_GRP_P8 3'h4
`define GP_GRP_MISC 3'h5

// Registers within a bidirectional port group
`define GP_REG_LATCH 3'h0
`define GP_REG_DIR 3'h1
`define GP_REG_ODRAIN 3'h2
`define GP_REG_ALTSEL 3'h3
`define GP_REG_PIN 3'h4

// Registers within the misc group
`define GP_REG_P5PIN 3'h0
`define GP_REG_THRESH 3'h1

// Reset values and masks
`define GP_RST_16 16'h0000
`define GP_RST_8 8'h00
`define GP_RST_THR 6'h00
`define GP_RST_32 32'h00000000
`define GP_ALL_16 16'hFFFF
`define GP_ALL_8 8'hFF
`define GP_P3_IMPL 16'hBFFF
`define GP_P3_ALTDRV 16'h0002
`define GP_THR_W 6

`endif

//--- gp_pin_bank.v
`timescale 1ns/1ps
`include "gp_defines.vh"

// One bidirectional port: latch, direction, drive mode, alternate select and pin sampling
module gp_pin_bank #(
    parameter W = 16,
    parameter [W-1:0] IMPL = {W{1'b1}}
) (
    input wire pclk,
    input wire presetn,
    input wire [W-1:0] wr_data,
    input wire wr_latch,
    input wire wr_dir,
    input wire wr_od,
    input wire wr_alt,
    input wire [W-1:0] alt_val,
    input wire [W-1:0] alt_drv,
    input wire [W-1:0] pad_in,
    output reg [W-1:0] pad_out,
    output reg [W-1:0] pad_oe,
    output reg [W-1:0] latch_reg,
    output reg [W-1:0] dir_reg,
    output reg [W-1:0] od_reg,
    output reg [W-1:0] alt_reg,
    output reg [W-1:0] pin_reg
);

    wire [W-1:0] use_alt;
    wire [W-1:0] drv_next;

    // Peripheral value replaces the latch only where it is selected and driving
    assign use_alt = alt_reg & alt_drv;
    assign drv_next = (use_alt & alt_val) | (~use_alt & latch_reg);

    // Software registers; missing bits are held at zero
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_reg <= {W{1'b0}};
            dir_reg <= {W{1'b0}};
            od_reg <= {W{1'b0}};
            alt_reg <= {W{1'b0}};
        end else begin
            if (wr_latch) begin
                latch_reg <= wr_data & IMPL;
            end
            if (wr_dir) begin
                dir_reg <= wr_data & IMPL;
            end
            if (wr_od) begin
                od_reg <= wr_data & IMPL;
            end
            if (wr_alt) begin
                alt_reg <= wr_data & IMPL;
            end
        end
    end

    // Pad drive registered so the pins never glitch on decode changes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_out <= {W{1'b0}};
            pad_oe <= {W{1'b0}};
            pin_reg <= {W{1'b0}};
        end else begin
            pad_out <= drv_next & ~od_reg & IMPL;
            pad_oe <= dir_reg & IMPL & ~(od_reg & drv_next);
            pin_reg <= pad_in & IMPL;
        end
    end

endmodule // gp_pin_bank

//--- gp_ports.v
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "gp_defines.vh"

module gp_ports (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output reg pslverr,
    input wire [15:0] p2_in,
    output wire [15:0] p2_out,
    output wire [15:0] p2_oe,
    input wire [15:0] p3_in,
    output wire [15:0] p3_out,
    output wire [15:0] p3_oe,
    input wire [15:0] p5_in,
    input wire [7:0] p6_in,
    output wire [7:0] p6_out,
    output wire [7:0] p6_oe,
    input wire [7:0] p7_in,
    output wire [7:0] p7_out,
    output wire [7:0] p7_oe,
    input wire [7:0] p8_in,
    output wire [7:0] p8_out,
    output wire [7:0] p8_oe,
    output wire [5:0] threshold_cmos_sel,
    input wire [4:0] chip_select_out_n,
    input wire bus_yield_grant_out_n,
    input wire bus_want_out_n,
    output wire bus_hold_request_in_n,
    input wire second_sync_serial_en,
    input wire second_sync_serial_clock_out,
    input wire second_sync_serial_clock_drive,
    input wire second_sync_serial_mosi_out,
    input wire second_sync_serial_miso_out,
    output wire second_sync_serial_clock_in,
    output wire second_sync_serial_mosi_in,
    output wire second_sync_serial_miso_in,
    input wire [15:0] first_capture_unit_cmp_out,
    output wire [15:0] first_capture_unit_cap_in,
    input wire [15:0] second_capture_unit_cmp_out,
    output wire [15:0] second_capture_unit_cap_in,
    input wire [3:0] extended_pwm_channel_out,
    input wire [3:0] extended_pwm_unit_en,
    input wire [3:0] basic_pwm_channel_out,
    input wire second_async_serial_en,
    input wire second_async_serial_tx,
    input wire second_async_serial_rx_out,
    input wire second_async_serial_rx_drive,
    output wire second_async_serial_rx,
    output wire [7:0] fast_ext_irq_in,
    output wire capture_timer_seven_count_in,
    output wire [15:0] analog_channel_in,
    output wire timer_six_updown_in,
    output wire timer_five_updown_in,
    output wire timer_six_count_in,
    output wire timer_five_count_in,
    output wire timer_four_updown_in,
    output wire timer_two_updown_in,
    output wire capture_timer_zero_count_in,
    input wire timer_six_toggle_out,
    output wire reload_register_capture_in
);

    wire [2:0] grp;
    wire [2:0] rsel;
    wire wr_acc;
    wire setup;
    wire [5:0] grp_hit;
    wire [15:0] wdata16;

    wire [15:0] p2_latch, p2_dir, p2_od, p2_alt, p2_pin;
    wire [15:0] p3_latch, p3_dir, p3_od, p3_alt, p3_pin;
    wire [7:0] p6_latch, p6_dir, p6_od, p6_alt, p6_pin;
    wire [7:0] p7_latch, p7_dir, p7_od, p7_alt, p7_pin;
    wire [7:0] p8_latch, p8_dir, p8_od, p8_alt, p8_pin;
    wire [7:0] p6_alt_val, p6_alt_drv, p8_alt_val, p8_alt_drv, p7_alt_drv;
    wire [15:0] p3_alt_val, p2_alt_drv, p3_alt_drv;

    reg [15:0] p5_pin_reg;
    reg [5:0] thresh_reg;
    reg [31:0] rd_next;
    reg err_next;

    // Address decode
    assign grp = paddr[`GP_GRP_HI:`GP_GRP_LO];
    assign rsel = paddr[`GP_REG_HI:`GP_REG_LO];
    assign setup = psel & ~penable;
    assign wr_acc = psel & penable & pwrite;
    assign wdata16 = pwdata[15:0];
    assign grp_hit[0] = wr_acc & (grp == `GP_GRP_P2);
    assign grp_hit[1] = wr_acc & (grp == `GP_GRP_P3);
    assign grp_hit[2] = wr_acc & (grp == `GP_GRP_P6);
    assign grp_hit[3] = wr_acc & (grp == `GP_GRP_P7);
    assign grp_hit[4] = wr_acc & (grp == `GP_GRP_P8);
    assign grp_hit[5] = wr_acc & (grp == `GP_GRP_MISC);

    // No wait states: read data is captured in the setup cycle
    assign pready = 1'b1;

    // Selects one of a port's registers, widened to 16 bits
    function [15:0] port_word;
        input [2:0] r;
        input [15:0] lat;
        input [15:0] dir;
        input [15:0] od;
        input [15:0] alt;
        input [15:0] pin;
        begin
            case (r)
                `GP_REG_LATCH: port_word = lat;
                `GP_REG_DIR: port_word = dir;
                `GP_REG_ODRAIN: port_word = od;
                `GP_REG_ALTSEL: port_word = alt;
                `GP_REG_PIN: port_word = pin;
                default: port_word = `GP_RST_16;
            endcase
        end
    endfunction

    // Sixteen-bit port: capture 0-15 compare outputs drive every bit
    assign p2_alt_drv = `GP_ALL_16;
    assign p3_alt_drv = `GP_P3_ALTDRV;
    assign p7_alt_drv = `GP_ALL_8;
    gp_pin_bank #(.W(16), .IMPL(`GP_ALL_16)) u_p2 (
        .pclk(pclk),
        .presetn(presetn),
        .wr_data(wdata16),
        .wr_latch(grp_hit[0] & (rsel == `GP_REG_LATCH)),
        .wr_dir(grp_hit[0] & (rsel == `GP_REG_DIR)),
        .wr_od(grp_hit[0] & (rsel == `GP_REG_ODRAIN)),
        .wr_alt(grp_hit[0] & (rsel == `GP_REG_ALTSEL)),
        .alt_val(first_capture_unit_cmp_out),
        .alt_drv(p2_alt_drv),
        .pad_in(p2_in),
        .pad_out(p2_out),
        .pad_oe(p2_oe),
        .latch_reg(p2_latch),
        .dir_reg(p2_dir),
        .od_reg(p2_od),
        .alt_reg(p2_alt),
        .pin_reg(p2_pin)
    );

    // Fifteen-bit port: only bit 1 has an output alternate; bit 14 has no pin
    assign p3_alt_val = {14'h0000, timer_six_toggle_out, 1'b0};
    gp_pin_bank #(.W(16), .IMPL(`GP_P3_IMPL)) u_p3 (
        .pclk(pclk),
        .presetn(presetn),
        .wr_data(wdata16),
        .wr_latch(grp_hit[1] & (rsel == `GP_REG_LATCH)),
        .wr_dir(grp_hit[1] & (rsel == `GP_REG_DIR)),
        .wr_od(grp_hit[1] & (rsel == `GP_REG_ODRAIN)),
        .wr_alt(grp_hit[1] & (rsel == `GP_REG_ALTSEL)),
        .alt_val(p3_alt_val),
        .alt_drv(p3_alt_drv),
        .pad_in(p3_in),
        .pad_out(p3_out),
        .pad_oe(p3_oe),
        .latch_reg(p3_latch),
        .dir_reg(p3_dir),
        .od_reg(p3_od),
        .alt_reg(p3_alt),
        .pin_reg(p3_pin)
    );

    // Bus-control port; serial channel takes bits 5-7 while it is enabled
    assign p6_alt_val[4:0] = chip_select_out_n;
    assign p6_alt_val[5] = second_sync_serial_clock_out;
    assign p6_alt_val[6] = second_sync_serial_en ? second_sync_serial_mosi_out :
        bus_yield_grant_out_n;
    assign p6_alt_val[7] = second_sync_serial_en ? second_sync_serial_miso_out :
        bus_want_out_n;
    // Hold request is input only; the clock drives only as serial master
    assign p6_alt_drv = {2'b11, second_sync_serial_en & second_sync_serial_clock_drive,
        5'h1F};
    gp_pin_bank #(.W(8), .IMPL(`GP_ALL_8)) u_p6 (
        .pclk(pclk),
        .presetn(presetn),
        .wr_data(pwdata[7:0]),
        .wr_latch(grp_hit[2] & (rsel == `GP_REG_LATCH)),
        .wr_dir(grp_hit[2] & (rsel == `GP_REG_DIR)),
        .wr_od(grp_hit[2] & (rsel == `GP_REG_ODRAIN)),
        .wr_alt(grp_hit[2] & (rsel == `GP_REG_ALTSEL)),
        .alt_val(p6_alt_val),
        .alt_drv(p6_alt_drv),
        .pad_in(p6_in),
        .pad_out(p6_out),
        .pad_oe(p6_oe),
        .latch_reg(p6_latch),
        .dir_reg(p6_dir),
        .od_reg(p6_od),
        .alt_reg(p6_alt),
        .pin_reg(p6_pin)
    );

    // Basic PWM on the low nibble, capture 28-31 on the high nibble
    gp_pin_bank #(.W(8), .IMPL(`GP_ALL_8)) u_p7 (
        .pclk(pclk),
        .presetn(presetn),
        .wr_data(pwdata[7:0]),
        .wr_latch(grp_hit[3] & (rsel == `GP_REG_LATCH)),
        .wr_dir(grp_hit[3] & (rsel == `GP_REG_DIR)),
        .wr_od(grp_hit[3] & (rsel == `GP_REG_ODRAIN)),
        .wr_alt(grp_hit[3] & (rsel == `GP_REG_ALTSEL)),
        .alt_val({second_capture_unit_cmp_out[15:12], basic_pwm_channel_out}),
        .alt_drv(p7_alt_drv),
        .pad_in(p7_in),
        .pad_out(p7_out),
        .pad_oe(p7_oe),
        .latch_reg(p7_latch),
        .dir_reg(p7_dir),
        .od_reg(p7_od),
        .alt_reg(p7_alt),
        .pin_reg(p7_pin)
    );

    // Capture 16-23 port; extended PWM and async serial override when enabled
    assign p8_alt_val[3:0] = (extended_pwm_unit_en & extended_pwm_channel_out) |
        (~extended_pwm_unit_en & second_capture_unit_cmp_out[3:0]);
    assign p8_alt_val[5:4] = second_capture_unit_cmp_out[5:4];
    assign p8_alt_val[6] = second_async_serial_en ? second_async_serial_rx_out :
        second_capture_unit_cmp_out[6];
    assign p8_alt_val[7] = second_async_serial_en ? second_async_serial_tx :
        second_capture_unit_cmp_out[7];
    // The data line drives only in synchronous mode; async it is a receive input
    assign p8_alt_drv = {1'b1, ~second_async_serial_en | second_async_serial_rx_drive,
        6'h3F};
    gp_pin_bank #(.W(8), .IMPL(`GP_ALL_8)) u_p8 (
        .pclk(pclk),
        .presetn(presetn),
        .wr_data(pwdata[7:0]),
        .wr_latch(grp_hit[4] & (rsel == `GP_REG_LATCH)),
        .wr_dir(grp_hit[4] & (rsel == `GP_REG_DIR)),
        .wr_od(grp_hit[4] & (rsel == `GP_REG_ODRAIN)),
        .wr_alt(grp_hit[4] & (rsel == `GP_REG_ALTSEL)),
        .alt_val(p8_alt_val),
        .alt_drv(p8_alt_drv),
        .pad_in(p8_in),
        .pad_out(p8_out),
        .pad_oe(p8_oe),
        .latch_reg(p8_latch),
        .dir_reg(p8_dir),
        .od_reg(p8_od),
        .alt_reg(p8_alt),
        .pin_reg(p8_pin)
    );

    // Input-only port and threshold selects; no driver exists for the former
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p5_pin_reg <= `GP_RST_16;
            thresh_reg <= `GP_RST_THR;
        end else begin
            p5_pin_reg <= p5_in;
            if (grp_hit[5] & (rsel == `GP_REG_THRESH)) begin
                thresh_reg <= pwdata[`GP_THR_W-1:0];
            end
        end
    end

    // One bit per port: 0 P2, 1 P3, 2 P5, 3 P6, 4 P7, 5 P8; set means CMOS
    assign threshold_cmos_sel = thresh_reg;

    // Alternate inputs see the same sampled value as a port read
    assign first_capture_unit_cap_in = p2_pin;
    assign fast_ext_irq_in = p2_pin[15:8];
    assign capture_timer_seven_count_in = p2_pin[15];
    assign capture_timer_zero_count_in = p3_pin[0];
    assign reload_register_capture_in = p3_pin[2];
    assign analog_channel_in = p5_pin_reg;
    assign timer_six_updown_in = p5_pin_reg[10];
    assign timer_five_updown_in = p5_pin_reg[11];
    assign timer_six_count_in = p5_pin_reg[12];
    assign timer_five_count_in = p5_pin_reg[13];
    assign timer_four_updown_in = p5_pin_reg[14];
    assign timer_two_updown_in = p5_pin_reg[15];
    assign bus_hold_request_in_n = p6_pin[5];
    assign second_sync_serial_clock_in = p6_pin[5];
    assign second_sync_serial_mosi_in = p6_pin[6];
    assign second_sync_serial_miso_in = p6_pin[7];
    // Channels 24-27 live on a port outside this block
    assign second_capture_unit_cap_in = {p7_pin[7:4], 4'h0, p8_pin};
    assign second_async_serial_rx = p8_pin[6];

    // Read mux and unmapped detection
    always @* begin
        rd_next = `GP_RST_32;
        err_next = 1'b0;
        case (grp)
            `GP_GRP_P2: rd_next[15:0] = port_word(rsel, p2_latch, p2_dir, p2_od, p2_alt, p2_pin);
            `GP_GRP_P3: rd_next[15:0] = port_word(rsel, p3_latch, p3_dir, p3_od, p3_alt, p3_pin);
            `GP_GRP_P6: rd_next[15:0] = port_word(rsel, {8'h00, p6_latch}, {8'h00, p6_dir},
                {8'h00, p6_od}, {8'h00, p6_alt}, {8'h00, p6_pin});
            `GP_GRP_P7: rd_next[15:0] = port_word(rsel, {8'h00, p7_latch}, {8'h00, p7_dir},
                {8'h00, p7_od}, {8'h00, p7_alt}, {8'h00, p7_pin});
            `GP_GRP_P8: rd_next[15:0] = port_word(rsel, {8'h00, p8_latch}, {8'h00, p8_dir},
                {8'h00, p8_od}, {8'h00, p8_alt}, {8'h00, p8_pin});
            `GP_GRP_MISC: begin
                if (rsel == `GP_REG_P5PIN) begin
                    rd_next[15:0] = p5_pin_reg;
                end else if (rsel == `GP_REG_THRESH) begin
                    rd_next[`GP_THR_W-1:0] = thresh_reg;
                end else begin
                    err_next = 1'b1;
                end
            end
            default: err_next = 1'b1;
        endcase
        if ((grp != `GP_GRP_MISC) && (rsel > `GP_REG_PIN)) begin
            err_next = 1'b1;
        end
    end

    // Answer registered at setup so prdata comes from flops with zero wait states
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= `GP_RST_32;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata <= pwrite ? `GP_RST_32 : rd_next;
            pslverr <= err_next;
        end
    end

endmodule // gp_ports

//--- dummy_end_marker_never_used.v
`timescale 1ns/1ps

//--- gp_ports_props.sv
`timescale 1ns/1ps

// Pin-side timing of the port block, all on pclk
module gp_ports_props (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire pslverr,
    input wire [15:0] p2_in,
    input wire [15:0] p2_oe,
    input wire [15:0] p3_in,
    input wire [15:0] p3_out,
    input wire [15:0] p3_oe,
    input wire [15:0] p5_in,
    input wire [7:0] p6_in,
    input wire [7:0] p6_oe,
    input wire [7:0] p8_in,
    input wire [15:0] analog_channel_in,
    input wire timer_two_updown_in,
    input wire [7:0] fast_ext_irq_in,
    input wire [15:0] first_capture_unit_cap_in,
    input wire capture_timer_zero_count_in,
    input wire reload_register_capture_in,
    input wire bus_hold_request_in_n,
    input wire second_async_serial_rx
);
    // One domain; nothing is judged while reset holds
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Drivers of P2, P3 and P6 stay off on the first edge out of reset
    property p_oe_reset;
        $rose(presetn) |-> (p2_oe == 16'h0000) && (p3_oe == 16'h0000) && (p6_oe == 8'h00);
    endproperty
    a_oe_reset: assert property (p_oe_reset) else $error("driver on after reset");
    property p_gap; (p3_oe[14] == 1'b0) && (p3_out[14] == 1'b0); endproperty
    a_gap: assert property (p_gap) else $error("missing pin driven");

    // Pin samples reach peripherals one edge late; the edge leaving reset is skipped
    property p_analog; $past(presetn) |-> analog_channel_in == $past(p5_in); endproperty
    a_analog: assert property (p_analog) else $error("analog channel mismatch");
    property p_timer; $past(presetn) |-> timer_two_updown_in == $past(p5_in[15]); endproperty
    a_timer: assert property (p_timer) else $error("timer input mismatch");
    property p_irq; $past(presetn) |-> fast_ext_irq_in == $past(p2_in[15:8]); endproperty
    a_irq: assert property (p_irq) else $error("fast irq input mismatch");
    property p_cap1; $past(presetn) |-> first_capture_unit_cap_in == $past(p2_in); endproperty
    a_cap1: assert property (p_cap1) else $error("capture input mismatch");
    property p_p3in;
        $past(presetn) |-> {reload_register_capture_in, capture_timer_zero_count_in}
            == {$past(p3_in[2]), $past(p3_in[0])};
    endproperty
    a_p3in: assert property (p_p3in) else $error("timer pin input mismatch");
    property p_hold; $past(presetn) |-> bus_hold_request_in_n == $past(p6_in[5]); endproperty
    a_hold: assert property (p_hold) else $error("hold request mismatch");
    property p_rx; $past(presetn) |-> second_async_serial_rx == $past(p8_in[6]); endproperty
    a_rx: assert property (p_rx) else $error("serial rx mismatch");

    // Main scenarios seen
    c_refused: cover property (psel && pslverr);
    c_p2_drive: cover property (p2_oe != 16'h0000);
    c_p6_drive: cover property (p6_oe != 8'h00);
endmodule // gp_ports_props

//--- gp_board.sv
`timescale 1ns/1ps

// Board side of one port: a pull-up on every line and a device that may pull
module gp_board #(
    parameter W = 16
) (
    input wire [W-1:0] pad_out,
    input wire [W-1:0] pad_oe,
    input wire [W-1:0] drv_val,
    input wire [W-1:0] drv_en,
    output wire [W-1:0] pad_in
);
    // Released lines go to the pull-up; two drivers resolve as wired-AND
    assign pad_in = (~pad_oe | pad_out) & (~drv_en | drv_val);
endmodule // gp_board

//--- io_ports_alt_function_test.sv
`timescale 1ns/1ps

// APB master, board models and read scoreboard around the port block
module io_ports_alt_function_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [63:0] pv = 64'h0;
    logic [6:0] en = 7'h00;
    logic [15:0] bv = 16'h0000;
    logic [15:0] be = 16'h0000;
    logic [15:0] lfsr = 16'h0021;
    logic [32:0] rq[$];
    int n_mismatch = 0;
    int n_checks = 0;
    wire pready, pslverr, bus_hold_request_in_n, second_async_serial_rx;
    wire second_sync_serial_clock_in, second_sync_serial_mosi_in, second_sync_serial_miso_in;
    wire capture_timer_seven_count_in, capture_timer_zero_count_in, reload_register_capture_in;
    wire timer_six_updown_in, timer_five_updown_in, timer_six_count_in, timer_five_count_in;
    wire timer_four_updown_in, timer_two_updown_in;
    wire [31:0] prdata;
    wire [15:0] p2_in, p2_out, p2_oe, p3_in, p3_out, p3_oe, p5_in, analog_channel_in;
    wire [15:0] first_capture_unit_cap_in, second_capture_unit_cap_in;
    wire [7:0] p6_in, p6_out, p6_oe, p7_in, p7_out, p7_oe, p8_in, p8_out, p8_oe, fast_ext_irq_in;
    wire [5:0] threshold_cmos_sel;
    wire [79:0] all_out = {8'h00, p8_out, 8'h00, p7_out, 8'h00, p6_out, p3_out, p2_out};
    wire [79:0] all_oe = {8'h00, p8_oe, 8'h00, p7_oe, 8'h00, p6_oe, p3_oe, p2_oe};

    initial begin
        forever #50 pclk = ~pclk;
    end

    gp_ports dut_u (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
        .p2_in, .p2_out, .p2_oe, .p3_in, .p3_out, .p3_oe, .p5_in, .p6_in, .p6_out, .p6_oe,
        .p7_in, .p7_out, .p7_oe, .p8_in, .p8_out, .p8_oe, .threshold_cmos_sel,
        .chip_select_out_n(pv[44:40]), .bus_yield_grant_out_n(pv[45]), .bus_want_out_n(pv[46]),
        .bus_hold_request_in_n, .second_sync_serial_en(en[4]),
        .second_sync_serial_clock_out(pv[47]), .second_sync_serial_clock_drive(pv[48]),
        .second_sync_serial_mosi_out(pv[49]), .second_sync_serial_miso_out(pv[50]),
        .second_sync_serial_clock_in, .second_sync_serial_mosi_in, .second_sync_serial_miso_in,
        .first_capture_unit_cmp_out(pv[15:0]), .first_capture_unit_cap_in,
        .second_capture_unit_cmp_out(pv[31:16]), .second_capture_unit_cap_in,
        .extended_pwm_channel_out(pv[35:32]), .extended_pwm_unit_en(en[3:0]),
        .basic_pwm_channel_out(pv[39:36]), .second_async_serial_en(en[5]),
        .second_async_serial_tx(pv[51]), .second_async_serial_rx_out(pv[52]),
        .second_async_serial_rx_drive(en[6]), .second_async_serial_rx, .fast_ext_irq_in,
        .capture_timer_seven_count_in, .analog_channel_in, .timer_six_updown_in,
        .timer_five_updown_in, .timer_six_count_in, .timer_five_count_in, .timer_four_updown_in,
        .timer_two_updown_in, .capture_timer_zero_count_in, .timer_six_toggle_out(pv[53]),
        .reload_register_capture_in
    );

    // Board on every port; the input-only port is never driven by the device
    gp_board #(.W(16)) b2_u (.pad_out(p2_out), .pad_oe(p2_oe), .drv_val(bv), .drv_en(be),
        .pad_in(p2_in));
    gp_board #(.W(16)) b3_u (.pad_out(p3_out), .pad_oe(p3_oe), .drv_val(bv), .drv_en(be),
        .pad_in(p3_in));
    assign p5_in = bv | ~be;
    gp_board #(.W(8)) b6_u (.pad_out(p6_out), .pad_oe(p6_oe), .drv_val(bv[7:0]),
        .drv_en(be[7:0]), .pad_in(p6_in));
    gp_board #(.W(8)) b7_u (.pad_out(p7_out), .pad_oe(p7_oe), .drv_val(bv[7:0]),
        .drv_en(be[7:0]), .pad_in(p7_in));
    gp_board #(.W(8)) b8_u (.pad_out(p8_out), .pad_oe(p8_oe), .drv_val(bv[7:0]),
        .drv_en(be[7:0]), .pad_in(p8_in));

    function automatic logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction

    // Implemented bits of each port group
    function automatic logic [15:0] msk(input int g);
        return (g == 1) ? 16'hBFFF : (g > 1) ? 16'h00FF : 16'hFFFF;
    endfunction

    task automatic check(input logic [79:0] s, input logic [79:0] e);
        n_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // One APB transfer, waiting boundedly for pready; a read queues its expected answer
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
        input logic [32:0] e);
        int i;
        if (!w) rq.push_back(e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 16);
        if (i >= 16) begin
            n_mismatch++;
            print_verdict();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Lets outputs launched at the last edge settle before they are looked at
    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask

    // Scoreboard: each completed read takes the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite)
            check({pslverr, prdata}, rq.pop_front());
    end

    initial begin
        logic [15:0] l, d, m, pn;
        int g, r, k;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        check(all_oe, 80'h0);
        for (g = 0; g < 5; g++) apb(8'(g * 32 + 4), 1'b0, 32'h0, 33'h0);
        // Board drives some lines, the rest float up; every input path except the first capture unit's is read back
        for (r = 0; r < 2; r++) begin
            @(posedge pclk);
            bv <= rnd();
            be <= rnd();
            settle(2);
            pn = bv | ~be;
            check(analog_channel_in, pn);
            check({timer_two_updown_in, timer_four_updown_in, timer_five_count_in,
                timer_six_count_in, timer_five_updown_in, timer_six_updown_in}, pn[15:10]);
            check({fast_ext_irq_in, capture_timer_seven_count_in}, {pn[15:8], pn[15]});
            check(second_capture_unit_cap_in, {pn[7:4], 4'h0, pn[7:0]});
            check({reload_register_capture_in, capture_timer_zero_count_in}, {pn[2], pn[0]});
            check({second_sync_serial_miso_in, second_sync_serial_mosi_in,
                second_sync_serial_clock_in, bus_hold_request_in_n, second_async_serial_rx},
                {pn[7:5], pn[5], pn[6]});
            for (g = 0; g < 5; g++) apb(8'(g * 32 + 16), 1'b0, 32'h0, {17'h0, pn & msk(g)});
            apb(8'hA0, 1'b0, 32'h0, {17'h0, pn});
        end
        // Each port: random latch and direction, push-pull then open drain
        be <= 16'h0000;
        for (g = 0; g < 5; g++) begin
            l = rnd();
            d = rnd();
            m = msk(g);
            apb(8'(g * 32), 1'b1, {rnd(), l}, 33'h0);
            apb(8'(g * 32 + 4), 1'b1, {16'h0, d}, 33'h0);
            settle(2);
            check({all_out[g * 16 +: 16], all_oe[g * 16 +: 16]}, {l & m, d & m});
            apb(8'(g * 32 + 8), 1'b1, 32'h0000FFFF, 33'h0);
            settle(2);
            check({all_out[g * 16 +: 16], all_oe[g * 16 +: 16]}, {16'h0, d & ~l & m});
            apb(8'(g * 32 + 4), 1'b0, 32'h0, {17'h0, d & m});
        end
        // All pins output and alternate; peripherals replace the latch where they drive
        l = rnd();
        for (g = 0; g < 5; g++) begin
            for (k = 0; k < 4; k++) apb(8'(g * 32 + k * 4), 1'b1,
                {16'h0, (k == 0) ? l : (k == 2) ? 16'h0000 : 16'hFFFF}, 33'h0);
        end
        for (r = 0; r < 2; r++) begin
            d = rnd();
            @(posedge pclk);
            pv <= {rnd(), rnd(), rnd(), rnd()};
            en <= {{3{r[0]}}, d[3:0] & {4{r[0]}}};
            settle(2);
            check(p2_out, pv[15:0]);
            check(p3_out, {l[15], 1'b0, l[13:2], pv[53], l[0]});
            check(p6_out[4:0], pv[44:40]);
            check(p7_out, {pv[31:28], pv[39:36]});
            check(p8_out, {en[5] ? {pv[51], pv[52]} : pv[23:22], pv[21:20],
                (en[3:0] & pv[35:32]) | (~en[3:0] & pv[19:16])});
            if (r == 0) check(p6_out[7:5], {pv[46:45], l[5]});
            else check(p6_out[7:5], {pv[50:49], pv[48] ? pv[47] : l[5]});
        end
        // Threshold select, then refused places
        d = rnd();
        apb(8'hA4, 1'b1, {26'h0, d[5:0]}, 33'h0);
        apb(8'hA4, 1'b0, 32'h0, {27'h0, d[5:0]});
        check(threshold_cmos_sel, d[5:0]);
        apb(8'hC0, 1'b0, 32'h0, {1'b1, 32'h0});
        apb(8'h34, 1'b0, 32'h0, {1'b1, 32'h0});
        // Second reset mid-run releases every driver at once
        presetn <= 1'b0;
        settle(1);
        check(all_oe, 80'h0);
        @(posedge pclk);
        presetn <= 1'b1;
        settle(2);
        print_verdict();
    end
endmodule // io_ports_alt_function_test

bind gp_ports gp_ports_props chk_u (.pclk, .presetn, .psel, .pslverr, .p2_in, .p2_oe, .p3_in,
    .p3_out, .p3_oe, .p5_in, .p6_in, .p6_oe, .p8_in, .analog_channel_in, .timer_two_updown_in,
    .fast_ext_irq_in, .first_capture_unit_cap_in, .capture_timer_zero_count_in,
    .reload_register_capture_in, .bus_hold_request_in_n, .second_async_serial_rx);
